// ### src/ptmr_paired_timer.sv
// paired 16/32-bit timer with classic wishbone register slave

// ========================================
// per-timer count clock: pin sync, gating and prescale
module ptmr_tick_gen (
   input  wire logic       clk,
   input  wire logic       srst,
   input  wire logic       enable,
   input  wire logic       extClkPin,
   input  wire logic       gatePin,
   input  wire logic       clkSrcSel,
   input  wire logic       gateEn,
   input  wire logic [1:0] prescSel,
   output logic            tick
);
   logic [7:0] prescCnt_reg, prescCnt_next, tc;
   logic       ckS0_reg, ckS1_reg, ckPrev_reg;
   logic       gtS0_reg, gtS1_reg;
   logic       tick_next, raw;

   always_comb begin
      case (prescSel)
         2'b00:   tc = ptmr_pkg::PRESC_TC_1;
         2'b01:   tc = ptmr_pkg::PRESC_TC_8;
         2'b10:   tc = ptmr_pkg::PRESC_TC_64;
         default: tc = ptmr_pkg::PRESC_TC_256;
      endcase
      // pin rising edge, or every clk while the gate pin allows it
      if (clkSrcSel) begin
         raw = ckS1_reg & ~ckPrev_reg;
      end else begin
         raw = gateEn ? gtS1_reg : 1'b1;
      end
      prescCnt_next = prescCnt_reg;
      tick_next = 1'b0;
      // stopped timer restarts its prescaler from zero
      if (!enable) begin
         prescCnt_next = ptmr_pkg::PRESC_RESET;
      end else if (raw) begin
         if (prescCnt_reg == tc) begin
            prescCnt_next = ptmr_pkg::PRESC_RESET;
            tick_next = 1'b1;
         end else begin
            prescCnt_next = prescCnt_reg + 8'h01;
         end
      end
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         prescCnt_reg <= ptmr_pkg::PRESC_RESET;
         tick         <= 1'b0;
         ckS0_reg     <= 1'b0;
         ckS1_reg     <= 1'b0;
         ckPrev_reg   <= 1'b0;
         gtS0_reg     <= 1'b0;
         gtS1_reg     <= 1'b0;
      end else begin
         prescCnt_reg <= prescCnt_next;
         tick         <= tick_next;
         ckS0_reg     <= extClkPin;
         ckS1_reg     <= ckS0_reg;
         ckPrev_reg   <= ckS1_reg;
         gtS0_reg     <= gatePin;
         gtS1_reg     <= gtS0_reg;
      end
   end
endmodule // ptmr_tick_gen

// ========================================
// top: register slave, counters, match logic
module ptmr_paired_timer (
   input  wire logic        clk,
   input  wire logic        srst,
   input  wire logic        wbCyc,
   input  wire logic        wbStb,
   input  wire logic        wbWe,
   input  wire logic [7:0]  wbAdr,
   input  wire logic [3:0]  wbSel,
   input  wire logic [31:0] wbDatIn,
   output logic [31:0]      wbDatOut,
   output logic             wbAck,
   input  wire logic        idleMode,
   input  wire logic        lowExtClkPin,
   input  wire logic        highExtClkPin,
   input  wire logic        lowGatePin,
   input  wire logic        highGatePin,
   output logic [15:0]      lowCount,
   output logic [15:0]      highCount,
   output logic             lowIrqPulse,
   output logic             highIrqPulse,
   output logic [2:0]       lowIrqPrio,
   output logic [2:0]       highIrqPrio,
   output logic             adcTrigger
);
   ptmr_pkg::ptmr_ctrl_t    lowCtrl_reg, lowCtrl_next;
   ptmr_pkg::ptmr_ctrl_t    highCtrl_reg, highCtrl_next;
   ptmr_pkg::ptmr_irq_cfg_t irqCfg_reg, irqCfg_next;
   logic [15:0] lowPer_reg, lowPer_next, highPer_reg, highPer_next;
   logic [15:0] lowCnt_next, highCnt_next;
   logic [31:0] rdData, pairCnt, pairPer;
   logic        ack_next, lowIrq_next, highIrq_next, adc_next;
   logic        req, wr, pairOn, lowEn, highEn, lowTick, highTick;
   logic        wrLowCnt, wrHighCnt;
   function automatic logic [15:0] laneMerge(input logic [15:0] old,
                                             input logic [31:0] d,
                                             input logic [3:0] sel);
      laneMerge = {sel[1] ? d[15:8] : old[15:8], sel[0] ? d[7:0] : old[7:0]};
   endfunction
   // ========================================
   // run control and idle handling
   // pair mode bit
   assign pairOn = lowCtrl_reg.pairModeSelect;
   // low run bit starts pair or low alone
   // pair halts in idle unless both stop bits clear
   assign lowEn  = lowCtrl_reg.run & ~(idleMode & (lowCtrl_reg.idleStop |
                   (pairOn & highCtrl_reg.idleStop)));
   assign highEn = ~pairOn & highCtrl_reg.run &
                   ~(idleMode & highCtrl_reg.idleStop);

   // pair clocked and gated by low inputs
   ptmr_tick_gen lowGen (
      .clk(clk), .srst(srst), .enable(lowEn), .tick(lowTick),
      .extClkPin(lowExtClkPin), .gatePin(lowGatePin),
      .clkSrcSel(lowCtrl_reg.clockSourceSelect),
      .gateEn(lowCtrl_reg.gateEnable),
      .prescSel(lowCtrl_reg.prescaleSelect));
   ptmr_tick_gen highGen (
      .clk(clk), .srst(srst), .enable(highEn), .tick(highTick),
      .extClkPin(highExtClkPin), .gatePin(highGatePin),
      .clkSrcSel(highCtrl_reg.clockSourceSelect),
      .gateEn(highCtrl_reg.gateEnable),
      .prescSel(highCtrl_reg.prescaleSelect));

   // ========================================
   // wishbone slave, one wait state
   assign req       = wbCyc & wbStb & ~wbAck;
   assign wr        = req & wbWe;
   assign wrLowCnt  = wr & (wbAdr == ptmr_pkg::OFF_LOW_CNT);
   assign wrHighCnt = wr & (wbAdr == ptmr_pkg::OFF_HIGH_CNT);
   assign pairCnt   = {highCount, lowCount};
   // pair period from both period words
   assign pairPer   = {highPer_reg, lowPer_reg};

   always_comb begin
      ack_next      = req;
      lowCtrl_next  = lowCtrl_reg;
      highCtrl_next = highCtrl_reg;
      irqCfg_next   = irqCfg_reg;
      lowPer_next   = lowPer_reg;
      highPer_next  = highPer_reg;
      rdData        = 32'h0000_0000;
      case (wbAdr)
         ptmr_pkg::OFF_LOW_CTRL:  rdData[15:0] = lowCtrl_reg;
         ptmr_pkg::OFF_HIGH_CTRL: rdData[15:0] = highCtrl_reg;
         ptmr_pkg::OFF_LOW_CNT:   rdData[15:0] = lowCount;
         ptmr_pkg::OFF_HIGH_CNT:  rdData[15:0] = highCount;
         ptmr_pkg::OFF_LOW_PER:   rdData[15:0] = lowPer_reg;
         ptmr_pkg::OFF_HIGH_PER:  rdData[15:0] = highPer_reg;
         ptmr_pkg::OFF_IRQ_CFG:   rdData[7:0]  = irqCfg_reg;
         default:                 rdData       = 32'h0000_0000;
      endcase
      if (wr) begin
         case (wbAdr)
            ptmr_pkg::OFF_LOW_CTRL: lowCtrl_next =
               laneMerge(lowCtrl_reg, wbDatIn, wbSel) &
               ptmr_pkg::LOW_CTRL_MASK;
            ptmr_pkg::OFF_HIGH_CTRL: highCtrl_next =
               laneMerge(highCtrl_reg, wbDatIn, wbSel) &
               ptmr_pkg::HIGH_CTRL_MASK;
            ptmr_pkg::OFF_LOW_PER:
               lowPer_next = laneMerge(lowPer_reg, wbDatIn, wbSel);
            ptmr_pkg::OFF_HIGH_PER:
               highPer_next = laneMerge(highPer_reg, wbDatIn, wbSel);
            ptmr_pkg::OFF_IRQ_CFG: begin
               if (wbSel[0]) begin
                  irqCfg_next = wbDatIn[7:0] & ptmr_pkg::IRQ_CFG_MASK;
               end
            end
            default: ;
         endcase
      end
   end

   // ========================================
   // counters and period match
   always_comb begin
      lowCnt_next  = lowCount;
      highCnt_next = highCount;
      lowIrq_next  = 1'b0;
      highIrq_next = 1'b0;
      adc_next     = 1'b0;
      if (pairOn) begin
         if (lowTick) begin
            if (pairCnt == pairPer) begin
               {highCnt_next, lowCnt_next} = 32'h0000_0000;
               highIrq_next = irqCfg_reg.highEn;
               adc_next = 1'b1;
            end else begin
               {highCnt_next, lowCnt_next} = pairCnt + 32'h0000_0001;
            end
         end
      end else begin
         if (lowTick) begin
            if (lowCount == lowPer_reg) begin
               lowCnt_next = ptmr_pkg::COUNT_RESET;
               lowIrq_next = irqCfg_reg.lowEn;
            end else begin
               lowCnt_next = lowCount + 16'h0001;
            end
         end
         if (highTick) begin
            if (highCount == highPer_reg) begin
               highCnt_next = ptmr_pkg::COUNT_RESET;
               highIrq_next = irqCfg_reg.highEn;
            end else begin
               highCnt_next = highCount + 16'h0001;
            end
         end
      end
      // software load wins over a count in the same cycle
      if (wrLowCnt) begin
         lowCnt_next = laneMerge(lowCount, wbDatIn, wbSel);
      end
      if (wrHighCnt) begin
         highCnt_next = laneMerge(highCount, wbDatIn, wbSel);
      end
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         lowCtrl_reg  <= ptmr_pkg::CTRL_RESET;
         highCtrl_reg <= ptmr_pkg::CTRL_RESET;
         irqCfg_reg   <= ptmr_pkg::IRQ_CFG_RESET;
         lowPer_reg   <= ptmr_pkg::PERIOD_RESET;
         highPer_reg  <= ptmr_pkg::PERIOD_RESET;
         lowCount     <= ptmr_pkg::COUNT_RESET;
         highCount    <= ptmr_pkg::COUNT_RESET;
         wbAck        <= 1'b0;
         wbDatOut     <= 32'h0000_0000;
         lowIrqPulse  <= 1'b0;
         highIrqPulse <= 1'b0;
         adcTrigger   <= 1'b0;
      end else begin
         lowCtrl_reg  <= lowCtrl_next;
         highCtrl_reg <= highCtrl_next;
         irqCfg_reg   <= irqCfg_next;
         lowPer_reg   <= lowPer_next;
         highPer_reg  <= highPer_next;
         // both counts exported as time bases
         lowCount     <= lowCnt_next;
         highCount    <= highCnt_next;
         wbAck        <= ack_next;
         wbDatOut     <= req ? rdData : 32'h0000_0000;
         lowIrqPulse  <= lowIrq_next;
         highIrqPulse <= highIrq_next;
         adcTrigger   <= adc_next;
      end
   end

   assign lowIrqPrio  = irqCfg_reg.lowPrio;
   assign highIrqPrio = irqCfg_reg.highPrio;
   // ========================================
   // checks
   default clocking cb @(posedge clk); endclocking
   default disable iff (srst);
   ack_answer_a: assert property (wbCyc && wbStb && !wbAck |=> wbAck)
      else $error("ack missing after request");
   ack_drop_a: assert property (wbAck |=> !wbAck)
      else $error("ack held longer than one cycle");
   reserved_zero_a: assert property (
      ((lowCtrl_reg & ~ptmr_pkg::LOW_CTRL_MASK) == 16'h0000) &&
      ((highCtrl_reg & ~ptmr_pkg::HIGH_CTRL_MASK) == 16'h0000))
      else $error("reserved control bit set");
   high_ignored_a: assert property (
      pairOn && $past(pairOn) |-> !highTick)
      else $error("high timer ticked in pair mode");
   // adc trigger only from a pair match
   adc_pair_a: assert property (adcTrigger |-> $past(pairOn) &&
      $past(lowTick) && $past(pairCnt) == $past(pairPer))
      else $error("adc trigger without pair match");
   low_irq_quiet_a: assert property (lowIrqPulse |-> !$past(pairOn))
      else $error("low interrupt in pair mode");
   // pair match raises enabled high interrupt
   pair_match_a: assert property (pairOn && lowTick &&
      pairCnt == pairPer && irqCfg_reg.highEn |=> highIrqPulse && adcTrigger)
      else $error("pair match not signalled");
   pair_wrap_a: assert property (pairOn && lowTick && !wrLowCnt &&
      !wrHighCnt && pairCnt == pairPer |=> pairCnt == 32'h0000_0000)
      else $error("pair count did not wrap");
   // lone low timer increments by one
   low_incr_a: assert property (!pairOn && lowTick && !wrLowCnt &&
      lowCount != lowPer_reg |=> lowCount == $past(lowCount) + 16'h0001)
      else $error("low count step wrong");
   // stopped low timer holds its count
   run_stop_a: assert property (!lowCtrl_reg.run && !wrLowCnt &&
      $past(!lowCtrl_reg.run) |=> $stable(lowCount))
      else $error("low count moved while stopped");
endmodule // ptmr_paired_timer

// ### src/ptmr_pkg.sv
// package: constants, offsets and types for the paired timer
package ptmr_pkg;
   // ========================================
   // register offsets (byte addresses)
   localparam logic [7:0] OFF_LOW_CTRL  = 8'h00;
   localparam logic [7:0] OFF_HIGH_CTRL = 8'h04;
   localparam logic [7:0] OFF_LOW_CNT   = 8'h08;
   localparam logic [7:0] OFF_HIGH_CNT  = 8'h0c;
   localparam logic [7:0] OFF_LOW_PER   = 8'h10;
   localparam logic [7:0] OFF_HIGH_PER  = 8'h14;
   localparam logic [7:0] OFF_IRQ_CFG   = 8'h18;
   // ========================================
   // implemented bits of each control register
   localparam logic [15:0] LOW_CTRL_MASK  = 16'ha07a;
   localparam logic [15:0] HIGH_CTRL_MASK = 16'ha072;
   localparam logic [7:0]  IRQ_CFG_MASK   = 8'hff;
   // ========================================
   // reset values
   localparam logic [15:0] CTRL_RESET    = 16'h0000;
   localparam logic [15:0] COUNT_RESET   = 16'h0000;
   localparam logic [15:0] PERIOD_RESET  = 16'hffff;
   localparam logic [7:0]  IRQ_CFG_RESET = 8'h00;
   localparam logic [7:0]  PRESC_RESET   = 8'h00;
   // ========================================
   // prescale terminal counts (divide minus one)
   localparam logic [7:0] PRESC_TC_1   = 8'h00;
   localparam logic [7:0] PRESC_TC_8   = 8'h07;
   localparam logic [7:0] PRESC_TC_64  = 8'h3f;
   localparam logic [7:0] PRESC_TC_256 = 8'hff;
   // ========================================
   // control register layout, bit 15 first
   typedef struct packed {
      logic       run;
      logic       rsv14;
      logic       idleStop;
      logic [5:0] rsv12to7;
      logic       gateEnable;
      logic [1:0] prescaleSelect;
      logic       pairModeSelect;
      logic       rsv2;
      logic       clockSourceSelect;
      logic       rsv0;
   } ptmr_ctrl_t;
   // interrupt enable and priority per half
   typedef struct packed {
      logic [2:0] highPrio;
      logic       highEn;
      logic [2:0] lowPrio;
      logic       lowEn;
   } ptmr_irq_cfg_t;
endpackage

// ### verification/tb_top.sv
// self-checking bench for the paired 16/32-bit timer
module tb_top;
   timeunit 1ns;
   timeprecision 1ns;
   // ========================================
   // signals
   logic        clk, srst, wbCyc, wbStb, wbWe, wbAck, idleMode;
   logic [7:0]  wbAdr;
   logic [3:0]  wbSel;
   logic [31:0] wbDatIn, wbDatOut;
   logic        lowExtClkPin, highExtClkPin, lowGatePin, highGatePin;
   logic [15:0] lowCount, highCount;
   logic        lowIrqPulse, highIrqPulse, adcTrigger, adcSeen;
   logic [2:0]  lowIrqPrio, highIrqPrio;
   int          fails, comparisons, cycles;
   int          divs[4] = '{1, 8, 64, 256};

   ptmr_paired_timer dut (.clk(clk), .srst(srst), .wbCyc(wbCyc),
      .wbStb(wbStb), .wbWe(wbWe), .wbAdr(wbAdr), .wbSel(wbSel),
      .wbDatIn(wbDatIn), .wbDatOut(wbDatOut), .wbAck(wbAck),
      .idleMode(idleMode), .lowExtClkPin(lowExtClkPin),
      .highExtClkPin(highExtClkPin), .lowGatePin(lowGatePin),
      .highGatePin(highGatePin), .lowCount(lowCount),
      .highCount(highCount), .lowIrqPulse(lowIrqPulse),
      .highIrqPulse(highIrqPulse), .lowIrqPrio(lowIrqPrio),
      .highIrqPrio(highIrqPrio), .adcTrigger(adcTrigger));

   initial begin
      clk = 1'b0;
      forever #50 clk = ~clk;
   end
   // ========================================
   // hang guard and trigger monitor
   always @(posedge clk) begin
      cycles++;
      if (adcTrigger === 1'b1) adcSeen = 1'b1;
      if (cycles == 20000) begin
         fails++;
         wrap_up();
      end
   end
   // ========================================
   // shared tasks
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      comparisons++;
      if (got !== exp) begin
         fails++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   // classic cycle: hold until ack sampled high, then release one cycle
   task automatic wb(input logic we, input logic [7:0] adr,
                     input logic [31:0] dat, output logic [31:0] rd);
      int n;
      n = 0;
      wbCyc <= 1'b1; wbStb <= 1'b1; wbWe <= we;
      wbAdr <= adr; wbSel <= 4'h3; wbDatIn <= dat;
      do begin
         @(posedge clk);
         n++;
      end while (wbAck !== 1'b1);
      rd = wbDatOut;
      // one wait state: ack is sampled high at the second edge
      chk(n, 32'h2);
      wbCyc <= 1'b0; wbStb <= 1'b0; wbWe <= 1'b0;
      @(posedge clk);
   endtask

   task automatic wr(input logic [7:0] adr, input logic [31:0] dat);
      logic [31:0] rd;
      wb(1'b1, adr, dat, rd);
   endtask

   task automatic rd_chk(input logic [7:0] adr, input logic [31:0] exp);
      logic [31:0] rd;
      wb(1'b0, adr, 32'h0, rd);
      chk(rd, exp);
   endtask

   // edges until the chosen pulse is sampled high, bounded
   task automatic wait_pulse(input bit high, output int n);
      n = 0;
      do begin
         @(posedge clk);
         n++;
      end while ((high ? highIrqPulse : lowIrqPulse) !== 1'b1 && n < 2000);
   endtask
   // ========================================
   // scenarios
   task automatic t_regs;
      rd_chk(ptmr_pkg::OFF_LOW_CTRL, 32'h0);
      rd_chk(ptmr_pkg::OFF_HIGH_CTRL, 32'h0);
      rd_chk(ptmr_pkg::OFF_HIGH_PER, 32'h0000ffff);
      wr(ptmr_pkg::OFF_LOW_CTRL, 32'h00005f85);
      rd_chk(ptmr_pkg::OFF_LOW_CTRL, 32'h0);
      wr(ptmr_pkg::OFF_HIGH_CTRL, 32'h00005f8d);
      rd_chk(ptmr_pkg::OFF_HIGH_CTRL, 32'h0);
      wr(ptmr_pkg::OFF_HIGH_CTRL, 32'h00002072);
      rd_chk(ptmr_pkg::OFF_HIGH_CTRL, 32'h00002072);
      wr(ptmr_pkg::OFF_HIGH_CTRL, 32'h0);
      wr(8'h1c, 32'h0000ffff);
      rd_chk(8'h1c, 32'h0);
      wr(ptmr_pkg::OFF_IRQ_CFG, 32'h000000bb);
      chk(highIrqPrio, 3'h5);
      chk(lowIrqPrio, 3'h5);
   endtask

   // lone low timer, period 2: pulse spacing is three divided ticks
   task automatic t_presc;
      int n;
      adcSeen = 1'b0;
      for (int c = 0; c < 4; c++) begin
         wr(ptmr_pkg::OFF_LOW_CTRL, 32'h0);
         wr(ptmr_pkg::OFF_LOW_CNT, 32'h0);
         wr(ptmr_pkg::OFF_LOW_PER, 32'h2);
         wr(ptmr_pkg::OFF_LOW_CTRL, 32'h8000 | (c << 4));
         wait_pulse(1'b0, n);
         wait_pulse(1'b0, n);
         chk(n, 3 * divs[c]);
         chk(lowCount, 16'h0);
      end
      chk(adcSeen, 1'b0);
   endtask

   task automatic t_high;
      int n;
      wr(ptmr_pkg::OFF_LOW_CTRL, 32'h0);
      wr(ptmr_pkg::OFF_HIGH_CNT, 32'h0);
      wr(ptmr_pkg::OFF_HIGH_PER, 32'h3);
      wr(ptmr_pkg::OFF_HIGH_CTRL, 32'h8010);
      wait_pulse(1'b1, n);
      wait_pulse(1'b1, n);
      chk(n, 32);
      chk(highCount, 16'h0);
      // external edges on the high pin, its gate ignored
      wr(ptmr_pkg::OFF_HIGH_CTRL, 32'h0);
      wr(ptmr_pkg::OFF_HIGH_CNT, 32'h0);
      wr(ptmr_pkg::OFF_HIGH_CTRL, 32'h8042);
      repeat (3) begin
         highExtClkPin <= 1'b1;
         repeat (4) @(posedge clk);
         highExtClkPin <= 1'b0;
         repeat (4) @(posedge clk);
      end
      chk(highCount, 16'h3);
      wr(ptmr_pkg::OFF_HIGH_CTRL, 32'h0);
   endtask

   // pair: high control written slow on purpose, must be ignored
   task automatic t_pair;
      int n;
      wr(ptmr_pkg::OFF_LOW_CTRL, 32'h0008);
      wr(ptmr_pkg::OFF_HIGH_CTRL, 32'h8030);
      wr(ptmr_pkg::OFF_LOW_PER, 32'h2);
      wr(ptmr_pkg::OFF_HIGH_PER, 32'h1);
      wr(ptmr_pkg::OFF_LOW_CNT, 32'h0);
      wr(ptmr_pkg::OFF_HIGH_CNT, 32'h1);
      wr(ptmr_pkg::OFF_LOW_CTRL, 32'h8008);
      wait_pulse(1'b1, n);
      chk(n < 20, 1'b1);
      chk({highCount, lowCount}, 32'h0);
      chk(adcTrigger, 1'b1);
      chk(lowIrqPulse, 1'b0);
      wr(ptmr_pkg::OFF_LOW_CTRL, 32'h0008);
      wr(ptmr_pkg::OFF_LOW_PER, 32'hffff);
      wr(ptmr_pkg::OFF_HIGH_PER, 32'hffff);
      wr(ptmr_pkg::OFF_LOW_CNT, 32'hffff);
      wr(ptmr_pkg::OFF_HIGH_CNT, 32'h0);
      wr(ptmr_pkg::OFF_LOW_CTRL, 32'h8008);
      repeat (10) @(posedge clk);
      wr(ptmr_pkg::OFF_LOW_CTRL, 32'h0008);
      rd_chk(ptmr_pkg::OFF_HIGH_CNT, 32'h1);
      wr(ptmr_pkg::OFF_LOW_CTRL, 32'h0);
   endtask

   task automatic t_idle;
      logic [15:0] c;
      wr(ptmr_pkg::OFF_LOW_PER, 32'hffff);
      wr(ptmr_pkg::OFF_LOW_CNT, 32'h0);
      wr(ptmr_pkg::OFF_LOW_CTRL, 32'ha000);
      idleMode <= 1'b1;
      repeat (3) @(posedge clk);
      c = lowCount;
      repeat (20) @(posedge clk);
      chk(lowCount, c);
      wr(ptmr_pkg::OFF_LOW_CTRL, 32'h8000);
      repeat (3) @(posedge clk);
      c = lowCount;
      repeat (10) @(posedge clk);
      chk(lowCount, c + 16'h000a);
      // paired idle runs only with both stop bits clear
      wr(ptmr_pkg::OFF_HIGH_CTRL, 32'h2000);
      wr(ptmr_pkg::OFF_LOW_CTRL, 32'h8008);
      repeat (3) @(posedge clk);
      c = lowCount;
      repeat (10) @(posedge clk);
      chk(lowCount, c);
      wr(ptmr_pkg::OFF_HIGH_CTRL, 32'h0);
      repeat (3) @(posedge clk);
      c = lowCount;
      repeat (10) @(posedge clk);
      chk(lowCount, c + 16'h000a);
      idleMode <= 1'b0;
   endtask

   // external edges ignore the gate; internal gated counts gate high
   task automatic t_ext;
      logic [15:0] c;
      wr(ptmr_pkg::OFF_LOW_CTRL, 32'h0);
      wr(ptmr_pkg::OFF_LOW_CNT, 32'h0);
      wr(ptmr_pkg::OFF_LOW_CTRL, 32'h8042);
      repeat (5) begin
         lowExtClkPin <= 1'b1;
         repeat (4) @(posedge clk);
         lowExtClkPin <= 1'b0;
         repeat (4) @(posedge clk);
      end
      chk(lowCount, 16'h5);
      wr(ptmr_pkg::OFF_LOW_CTRL, 32'h0);
      wr(ptmr_pkg::OFF_LOW_CNT, 32'h0);
      wr(ptmr_pkg::OFF_LOW_CTRL, 32'h8040);
      repeat (10) @(posedge clk);
      chk(lowCount, 16'h0);
      lowGatePin <= 1'b1;
      repeat (4) @(posedge clk);
      c = lowCount;
      repeat (10) @(posedge clk);
      chk(lowCount, c + 16'h000a);
      lowGatePin <= 1'b0;
      wr(ptmr_pkg::OFF_LOW_CTRL, 32'h0);
      c = lowCount;
      repeat (5) @(posedge clk);
      chk(lowCount, c);
   endtask
   // ========================================
   // verdict
   task automatic wrap_up;
      $display("mismatches %0d comparisons %0d", fails, comparisons);
      if (fails == 0 && comparisons > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask

   initial begin
      fails = 0; comparisons = 0; cycles = 0; adcSeen = 1'b0;
      srst = 1'b1; wbCyc = 1'b0; wbStb = 1'b0; wbWe = 1'b0;
      wbAdr = 8'h00; wbSel = 4'h0; wbDatIn = 32'h0; idleMode = 1'b0;
      lowExtClkPin = 1'b0; highExtClkPin = 1'b0;
      lowGatePin = 1'b0; highGatePin = 1'b0;
      repeat (20) @(posedge clk);
      srst <= 1'b0;
      @(posedge clk);
      t_regs();
      t_presc();
      t_high();
      t_pair();
      t_idle();
      t_ext();
      wrap_up();
   end
endmodule // tb_top
